// *** flash_param_table_power_on_tb_top.sv ***
// Purpose: drive host registers, read table and status through the link, flags from device ports
// Assumes: 20 MHz clock, settle wait of the host is honoured
// Notes: random reads mixed with fixed corner reads
`timescale 1ns/1ns
module flash_param_table_power_on_tb_top;
  import fptpo_pkg::*;
  logic clk = 1'b0;
  logic srst;
  logic [4:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [1:0] lane_mode;
  logic wel_flag;
  logic deep_pd_flag;
  logic standby_flag;
  int failures = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000_003d;
  logic [1:0] lt [3] = '{LANE_1, LANE_2, LANE_4};

  fptpo_if i_fptpo_if ();
  fptpo_host i_fptpo_host (.clk(clk), .srst(srst), .bus(i_fptpo_if), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fptpo_dev i_fptpo_dev (.clk(clk), .srst(srst), .bus(i_fptpo_if), .lane_mode(lane_mode),
    .wel_flag(wel_flag), .deep_pd_flag(deep_pd_flag), .standby_flag(standby_flag));
  fptpo_checker i_fptpo_checker (.clk(clk), .srst(srst), .cs_n(i_fptpo_if.cs_n),
    .sclk(i_fptpo_if.sclk), .h_do(i_fptpo_if.h_do), .h_oe(i_fptpo_if.h_oe),
    .d_do(i_fptpo_if.d_do), .d_oe(i_fptpo_if.d_oe), .io(i_fptpo_if.io));

  initial begin
    forever #25 clk = ~clk;
  end

  task automatic end_of_test;
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("[ERR] %0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask : chk

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    xs = seed;
  endfunction : xs

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    case (a)
      24'h00_0061: exp_byte = 8'h36;
      24'h00_0063: exp_byte = 8'h27;
      24'h00_0060, 24'h00_0062: exp_byte = 8'h00;
      24'h00_0064: exp_byte = 8'h9c;
      24'h00_0065: exp_byte = 8'h49;
      24'h00_0068: exp_byte = 8'hd9;
      24'h00_0069: exp_byte = 8'hc8;
      default: exp_byte = 8'hff;
    endcase
  endfunction : exp_byte

  // one Avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin
      failures++;
      end_of_test();
    end
  endtask : av

  task automatic frame(input logic [1:0] ln, input logic [7:0] op, input logic ha,
                       input logic dm, input logic [2:0] len, input logic [23:0] a,
                       output logic [31:0] q);
    logic [31:0] c;
    int n;
    c = 32'h8000_0000;
    c[7:0] = op;
    c[9:8] = ln;
    c[10] = ha;
    c[11] = dm;
    c[14:12] = len;
    lane_mode <= ln;
    av(1'b1, REG_ADDR, {8'h00, a}, q);
    av(1'b1, REG_CTRL, c, q);
    for (n = 0; n < 200; n++) begin
      av(1'b0, REG_STAT, 32'h0000_0000, q);
      if (q[0] === 1'b0) break;
    end
    if (n == 200) begin
      failures++;
      end_of_test();
    end
    av(1'b0, REG_DATA, 32'h0000_0000, q);
  endtask : frame

  task automatic rd_chk(input logic [1:0] ln, input logic [23:0] a, input logic [2:0] len);
    logic [31:0] q;
    logic [31:0] e;
    logic [31:0] m;
    int k;
    e = 32'h0000_0000;
    m = 32'h0000_0000;
    for (k = 0; k < int'(len); k++) begin
      e[8*k+:8] = exp_byte(a + 24'(k));
      m[8*k+:8] = 8'hff;
    end
    frame(ln, OP_PARAM_RD, 1'b1, 1'b1, len, a, q);
    chk(q & m, e);
  endtask : rd_chk

  task automatic stat_chk(input logic [7:0] e);
    logic [31:0] q;
    frame(LANE_1, OP_RDSR, 1'b0, 1'b0, 3'h1, 24'h00_0000, q);
    chk({24'h00_0000, q[7:0]}, {24'h00_0000, e});
  endtask : stat_chk

  initial begin
    logic [31:0] q;
    logic [31:0] r;
    int i;
    int n;
    srst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    lane_mode = 2'h0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({29'h0, wel_flag, deep_pd_flag, standby_flag}, 32'h0000_0001);
    av(1'b1, REG_CTRL, 32'h8000_0006, q);
    repeat (8) @(posedge clk);
    chk({30'h0, i_fptpo_if.cs_n, wel_flag}, 32'h0000_0002);
    for (n = 0; n < 1000; n++) begin
      av(1'b0, REG_STAT, 32'h0000_0000, q);
      if (q[1] === 1'b1) break;
    end
    chk({31'h0, q[1]}, 32'h0000_0001);
    av(1'b0, 5'h10, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    stat_chk(8'h00);
    for (i = 0; i < 12; i++) rd_chk(lt[i / 4], 24'h00_0060 + 24'(4 * (i % 4)), 3'h4);
    repeat (12) begin
      r = xs();
      rd_chk(lt[r[7:5] % 3], r[4] ? 24'h00_0060 + 24'(r[3:0]) : r[31:8], 3'(r[10:8] % 5));
    end
    frame(LANE_1, OP_WREN, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    stat_chk(8'h02);
    frame(LANE_1, 8'h02, 1'b1, 1'b0, 3'h0, 24'h00_0060, q);
    rd_chk(LANE_4, 24'h00_0060, 3'h4);
    frame(LANE_1, OP_RST, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    stat_chk(8'h02);
    frame(LANE_1, OP_RSTEN, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    frame(LANE_1, OP_RST, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    stat_chk(8'h00);
    frame(LANE_1, OP_DP, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    chk({30'h0, deep_pd_flag, standby_flag}, 32'h0000_0002);
    frame(LANE_1, OP_PARAM_RD, 1'b1, 1'b1, 3'h4, 24'h00_0060, q);
    chk(q, 32'hffff_ffff);
    frame(LANE_1, OP_RDP, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    chk({30'h0, deep_pd_flag, standby_flag}, 32'h0000_0001);
    frame(LANE_1, OP_WREN, 1'b0, 1'b0, 3'h0, 24'h00_0000, q);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({29'h0, wel_flag, deep_pd_flag, standby_flag}, 32'h0000_0001);
    end_of_test();
  end

  initial begin
    #2500000;
    failures++;
    end_of_test();
  end
endmodule : flash_param_table_power_on_tb_top

// *** fptpo_checker.sv ***
// Purpose: link-level checks between host and flash ends
// Assumes: one clock, srst synchronous active high
// Notes: watches the shared interface signals only
`timescale 1ns/1ns
module fptpo_checker (
  input wire logic clk,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_do,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_do,
  input wire logic [3:0] d_oe,
  input wire logic [3:0] io
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  reset_idle_a: assert property ($fell(srst) |-> cs_n && !sclk && h_oe == 4'h0 && d_oe == 4'h0)
    else $error("link not idle after reset");
  no_contention_a: assert property ((h_oe & d_oe) == 4'h0)
    else $error("host and device drive one line");
  host_lanes_a: assert property (h_oe != 4'h0 |-> h_oe inside {4'h1, 4'h3, 4'hf})
    else $error("host lane enable pattern bad");
  dev_lanes_a: assert property (d_oe != 4'h0 |-> d_oe inside {4'h2, 4'h3, 4'hf})
    else $error("device lane enable pattern bad");
  dev_drive_a: assert property ((io & d_oe) == (d_do & d_oe))
    else $error("driven line does not show device data");
  deselect_quiet_a: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0 && !sclk)
    else $error("activity while deselected");
  sclk_period_a: assert property ($rose(sclk) |-> ##1 sclk ##1 !sclk)
    else $error("serial clock high time wrong");
  host_hold_a: assert property (sclk && $past(sclk) |-> $stable(h_do))
    else $error("host data moved while clock high");
  dev_hold_a: assert property (sclk && $past(sclk) |-> $stable(d_do) && $stable(d_oe))
    else $error("device data moved while clock high");
  frame_bound_a: assert property ($fell(cs_n) |-> ##[1:400] cs_n)
    else $error("frame never ended");
  cs_low_min_a: assert property ($fell(cs_n) |-> !cs_n [*4])
    else $error("frame too short");

  cover property ($fell(cs_n));
  cover property (d_oe == 4'h2);
  cover property (d_oe == 4'h3);
  cover property (d_oe == 4'hf);
endmodule : fptpo_checker

// *** fptpo_dev.sv ***
// Purpose: flash end answering parameter reads and simple commands
// Assumes: sclk slow enough to be sampled as a level on clk
// Notes: lane mode is latched while deselected
`timescale 1ns/1ns
module fptpo_dev (
  input wire logic clk,
  input wire logic srst,
  fptpo_if.dev bus,
  input wire logic [1:0] lane_mode,
  output logic wel_flag,
  output logic deep_pd_flag,
  output logic standby_flag
);
  import fptpo_pkg::*;
  typedef enum logic [2:0] {D_CMD, D_ADDR, D_DUMMY, D_DATA, D_IGNORE} fptpo_dstate_t;

  fptpo_dstate_t state_reg;
  logic sclk_q_reg;
  logic [1:0] mode_reg;
  logic [31:0] sh_reg;
  logic [5:0] cnt_reg;
  logic [23:0] rd_addr_reg;
  logic [7:0] out_sh_reg;
  logic [3:0] out_cnt_reg;
  logic stat_sel_reg;
  logic armed_reg;
  logic wel_reg;
  logic dpd_reg;
  logic sb_reg;
  logic [3:0] do_reg;
  logic [3:0] oe_reg;

  logic rise;
  logic fall;
  logic [2:0] w;
  logic [31:0] sh_next;
  logic [5:0] cnt_next;
  logic [7:0] opcode;
  logic cmd_hit;
  logic [23:0] rom_addr;
  logic [7:0] rom_byte;
  logic [7:0] next_byte;
  logic [7:0] cur_byte;
  logic reload;

  assign rise = bus.sclk & ~sclk_q_reg & ~bus.cs_n;
  assign fall = ~bus.sclk & sclk_q_reg & ~bus.cs_n;
  assign w = lane_w(mode_reg);
  assign sh_next = shin(sh_reg, bus.io, mode_reg, 1'b1); // R10
  assign cnt_next = cnt_reg + {3'b000, w};
  assign opcode = sh_next[7:0];
  assign cmd_hit = rise && (state_reg == D_CMD) && (cnt_next == CMD_BITS);
  assign rom_addr = rd_addr_reg + ADDR_STEP;
  assign reload = (out_cnt_reg == BYTE_BITS);

  fptpo_rom u_rom (
    .addr(rom_addr),
    .data(rom_byte)
  );

  always_comb begin
    next_byte = rom_byte;
    if (stat_sel_reg) begin
      next_byte = 8'h00;
      next_byte[SR_WEL_BIT] = wel_reg;
    end
    cur_byte = reload ? next_byte : out_sh_reg;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sclk_q_reg <= 1'b0;
    end else begin
      sclk_q_reg <= bus.sclk;
    end
  end

  // one lane count per frame
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_reg <= LANE_1;
    end else if (bus.cs_n) begin
      mode_reg <= lane_mode; // R10
    end
  end

  // power-on: standby, latch clear
  always_ff @(posedge clk) begin
    if (srst) begin
      wel_reg <= 1'b0; // R01
      dpd_reg <= 1'b0; // R01
      armed_reg <= 1'b0;
    end else if (cmd_hit) begin
      armed_reg <= (opcode == OP_RSTEN) && !dpd_reg; // R06
      if (dpd_reg) begin
        if (opcode == OP_RDP) begin
          dpd_reg <= 1'b0;
        end
      end else begin
        case (opcode)
          OP_WREN: wel_reg <= 1'b1;
          OP_WRDI: wel_reg <= 1'b0;
          OP_DP: dpd_reg <= 1'b1;
          OP_RST: begin
            if (armed_reg) begin
              wel_reg <= 1'b0; // R06
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sb_reg <= 1'b1; // R01
    end else begin
      sb_reg <= bus.cs_n && !dpd_reg;
    end
  end

  // frame sequencer, restarts whenever deselected
  always_ff @(posedge clk) begin
    if (srst || bus.cs_n) begin
      state_reg <= D_CMD;
      sh_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
      stat_sel_reg <= 1'b0;
    end else if (rise) begin
      case (state_reg)
        D_CMD: begin
          sh_reg <= sh_next;
          cnt_reg <= cnt_next;
          if (cnt_next == CMD_BITS) begin
            cnt_reg <= 6'h00;
            if (!dpd_reg && opcode == OP_PARAM_RD) begin
              state_reg <= D_ADDR;
            end else if (!dpd_reg && opcode == OP_RDSR) begin
              state_reg <= D_DATA;
              stat_sel_reg <= 1'b1;
            end else begin
              state_reg <= D_IGNORE;
            end
          end
        end
        D_ADDR: begin
          sh_reg <= sh_next;
          cnt_reg <= cnt_next;
          if (cnt_next == ADDR_BITS) begin
            cnt_reg <= 6'h00;
            state_reg <= D_DUMMY;
          end
        end
        D_DUMMY: begin
          cnt_reg <= cnt_reg + 6'h01; // R11
          if (cnt_reg + 6'h01 == DUMMY_CLKS) begin
            state_reg <= D_DATA;
          end
        end
        D_DATA: begin
        end
        D_IGNORE: begin
        end
        default: state_reg <= D_IGNORE;
      endcase
    end
  end

  // read pointer sits one below the next byte to send
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_addr_reg <= 24'h00_0000;
    end else if (rise && state_reg == D_ADDR && cnt_next == ADDR_BITS) begin
      rd_addr_reg <= sh_next[23:0] - ADDR_STEP;
    end else if (fall && state_reg == D_DATA && reload) begin
      rd_addr_reg <= rom_addr; // R12
    end
  end

  // data shifted out msb first on falling sclk
  always_ff @(posedge clk) begin
    if (srst || bus.cs_n) begin
      out_sh_reg <= 8'h00;
      out_cnt_reg <= BYTE_BITS;
      do_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (fall && state_reg == D_DATA) begin
      do_reg <= lane_out(cur_byte[7:4], mode_reg, 1'b1); // R10
      oe_reg <= lane_oe(mode_reg, 1'b1);
      out_sh_reg <= cur_byte << w;
      out_cnt_reg <= reload ? {1'b0, w} : out_cnt_reg + {1'b0, w};
    end
  end

  assign bus.d_do = do_reg;
  assign bus.d_oe = oe_reg;
  assign wel_flag = wel_reg;
  assign deep_pd_flag = dpd_reg;
  assign standby_flag = sb_reg;
endmodule : fptpo_dev

// *** fptpo_host.sv ***
// Purpose: host controller driving the link from Avalon-MM registers
// Assumes: software polls busy before starting a new frame
// Notes: sclk is clk divided by four
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ns
module fptpo_host (
  input wire logic clk,
  input wire logic srst,
  fptpo_if.host bus,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import fptpo_pkg::*;
  typedef enum logic [2:0] {H_IDLE, H_SEND, H_DUMMY, H_READ, H_END} fptpo_hstate_t;

  fptpo_hstate_t state_reg;
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [7:0] op_reg;
  logic [1:0] mode_reg;
  logic has_addr_reg;
  logic dummy_reg;
  logic [2:0] len_reg;
  logic [23:0] addr_reg;
  logic [31:0] data_reg;
  logic [11:0] settle_reg;
  logic settled_reg;
  logic [1:0] div_reg;
  logic sclk_reg;
  logic cs_n_reg;
  logic [31:0] tx_reg;
  logic [5:0] cnt_reg;
  logic [7:0] rx_reg;
  logic [3:0] do_reg;
  logic [3:0] oe_reg;

  logic acc;
  logic start;
  logic tick;
  logic [2:0] w;
  logic [5:0] cnt_next;
  logic [31:0] rx_next;
  logic [31:0] frame;

  assign acc = (avs_read || avs_write) && !wait_reg;
  assign start = acc && avs_write && avs_address == REG_CTRL && avs_writedata[CTRL_START]
                 && settled_reg && state_reg == H_IDLE; // R02
  assign tick = (div_reg == SCLK_DIV_LAST);
  assign w = lane_w(mode_reg);
  assign cnt_next = cnt_reg + {3'b000, w};
  assign rx_next = shin({24'h00_0000, rx_reg}, bus.io, mode_reg, 1'b0);
  assign frame = {avs_writedata[7:0], addr_reg};

  always_ff @(posedge clk) begin
    if (srst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= !((avs_read || avs_write) && wait_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_reg <= 32'h0000_0000;
    end else if ((avs_read || avs_write) && wait_reg) begin
      case (avs_address)
        REG_CTRL: rdata_reg <= {20'h0_0000, dummy_reg, has_addr_reg, mode_reg, op_reg};
        REG_ADDR: rdata_reg <= {8'h00, addr_reg};
        REG_DATA: rdata_reg <= data_reg;
        REG_STAT: rdata_reg <= {30'h0000_0000, settled_reg, state_reg != H_IDLE};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      op_reg <= 8'h00;
      mode_reg <= LANE_1;
      has_addr_reg <= 1'b0;
      dummy_reg <= 1'b0;
      len_reg <= 3'h0;
      addr_reg <= 24'h00_0000;
    end else if (acc && avs_write && state_reg == H_IDLE) begin
      if (avs_address == REG_CTRL) begin
        op_reg <= avs_writedata[7:0];
        mode_reg <= avs_writedata[9:8]; // R10
        has_addr_reg <= avs_writedata[CTRL_HASADDR];
        dummy_reg <= avs_writedata[CTRL_DUMMY]; // R11
        len_reg <= avs_writedata[14:12];
      end
      if (avs_address == REG_ADDR) begin
        addr_reg <= avs_writedata[23:0];
      end
    end
  end

  // settle delay after power-up before any frame
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_reg <= 12'h000;
      settled_reg <= 1'b0;
    end else if (!settled_reg) begin
      settle_reg <= settle_reg + 12'h001;
      settled_reg <= (settle_reg == SETTLE_LAST); // R02
    end
  end

  // divider wraps at its last count: sclk phase lasts two clocks
  always_ff @(posedge clk) begin
    if (srst || state_reg == H_IDLE) begin
      div_reg <= 2'h0;
    end else if (tick) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= H_IDLE;
      cs_n_reg <= 1'b1;
      sclk_reg <= 1'b0;
      tx_reg <= 32'h0000_0000;
      cnt_reg <= 6'h00;
      rx_reg <= 8'h00;
      do_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (start) begin
      state_reg <= H_SEND;
      cs_n_reg <= 1'b0;
      cnt_reg <= 6'h00;
      do_reg <= lane_out(frame[31:28], avs_writedata[9:8], 1'b0);
      oe_reg <= lane_oe(avs_writedata[9:8], 1'b0);
      tx_reg <= frame << lane_w(avs_writedata[9:8]);
    end else if (tick && state_reg == H_END) begin
      state_reg <= H_IDLE;
      cs_n_reg <= 1'b1;
    end else if (tick && state_reg != H_IDLE) begin
      sclk_reg <= !sclk_reg;
      if (!sclk_reg) begin
        case (state_reg)
          H_SEND: cnt_reg <= cnt_next;
          H_DUMMY: cnt_reg <= cnt_reg + 6'h01; // R11
          H_READ: begin
            cnt_reg <= cnt_next;
            rx_reg <= rx_next[7:0];
          end
          default: begin
          end
        endcase
      end else begin
        case (state_reg)
          H_SEND: begin
            if (cnt_reg == (has_addr_reg ? CMD_ADDR_BITS : CMD_BITS)) begin
              oe_reg <= 4'h0;
              cnt_reg <= 6'h00;
              state_reg <= dummy_reg ? H_DUMMY : (len_reg != 3'h0 ? H_READ : H_END);
            end else begin
              do_reg <= lane_out(tx_reg[31:28], mode_reg, 1'b0); // R10
              tx_reg <= tx_reg << w;
            end
          end
          H_DUMMY: begin
            if (cnt_reg == DUMMY_CLKS) begin
              cnt_reg <= 6'h00;
              state_reg <= (len_reg != 3'h0) ? H_READ : H_END;
            end
          end
          H_READ: begin
            if (cnt_reg == {len_reg, 3'b000}) begin
              state_reg <= H_END;
            end
          end
          default: state_reg <= H_END;
        endcase
      end
    end
  end

  // bytes land little-endian: first byte in bits 7:0
  always_ff @(posedge clk) begin
    if (srst || start) begin
      data_reg <= 32'h0000_0000;
    end else if (tick && !sclk_reg && state_reg == H_READ && cnt_next[2:0] == 3'h0) begin
      data_reg[{cnt_reg[4:3], 3'b000} +: 8] <= rx_next[7:0]; // R12
    end
  end

  assign bus.cs_n = cs_n_reg;
  assign bus.sclk = sclk_reg;
  assign bus.h_do = do_reg;
  assign bus.h_oe = oe_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
endmodule : fptpo_host

// *** fptpo_if.sv ***
// Purpose: serial link between host controller and flash end
// Assumes: lines idle high through a pull-up
// Notes: device drive wins over host drive
`timescale 1ns/1ns
interface fptpo_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_do;
  logic [3:0] h_oe;
  logic [3:0] d_do;
  logic [3:0] d_oe;
  logic [3:0] io;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_io
      assign io[i] = d_oe[i] ? d_do[i] : (h_oe[i] ? h_do[i] : 1'b1);
    end
  endgenerate
  modport host (output cs_n, output sclk, output h_do, output h_oe, input io);
  modport dev (input cs_n, input sclk, input io, output d_do, output d_oe);
endinterface : fptpo_if

// *** fptpo_pkg.sv ***
// Purpose: shared constants, lane helpers and parameter table contents
// Assumes: one 20 MHz clock, serial link sampled as ordinary inputs
// Notes: table bytes are fixed constants
//
// Summary of operation
// R01 - power-up in standby, write latch cleared
// R02 - host waits settle delay before commands
// R03 - bytes 60h,61h read 00h,36h
// R04 - bytes 62h,63h read 00h,27h
// R05 - feature word at 64h..65h reads 499Ch
// R06 - software reset is 66h then 99h
// R07 - bytes 66h,67h read FFh
// R08 - low half of 68h..6Bh reads C8D9h
// R09 - unused table locations read FFh
// R10 - opcode, address, data share lane count
// R11 - host adds dummy clocks after the address, no mode bits
// R12 - table is constant, little-endian, write-proof
package fptpo_pkg;
  localparam int CLK_MHZ = 20;
  localparam int SUPPLY_SETTLE_US = 100;
  localparam int SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_US * CLK_MHZ;
  localparam logic [11:0] SETTLE_LAST = 12'(SUPPLY_SETTLE_CYC - 1);
  localparam logic [1:0] SCLK_DIV_LAST = 2'h1;
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] CMD_ADDR_BITS = 6'h20;
  localparam logic [5:0] DUMMY_CLKS = 6'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] OP_PARAM_RD = 8'h5a;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RSTEN = 8'h66;
  localparam logic [7:0] OP_RST = 8'h99;
  localparam logic [7:0] OP_DP = 8'hb9;
  localparam logic [7:0] OP_RDP = 8'hab;
  localparam logic [7:0] OP_LOCK = 8'h36;
  localparam logic [7:0] BLANK = 8'hff;
  localparam logic [15:0] PT_VMAX = 16'h3600;
  localparam logic [15:0] PT_VMIN = 16'h2700;
  // reserved14, hold/susp off, reset opcode, sw reset, deep pd
  localparam logic [15:0] PT_FEAT = {1'b0, 1'b1, 1'b0, 1'b0, OP_RST,
                                     1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic [15:0] PT_LOCK = {2'b11, 1'b0, 1'b0, 1'b1, 1'b0, OP_LOCK,
                                     1'b0, 1'b1};
  localparam logic [23:0] PT_BASE = 24'h00_0060;
  localparam logic [23:0] ADDR_STEP = 24'h00_0001;
  localparam int SR_WEL_BIT = 1;
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_DATA = 5'h08;
  localparam logic [4:0] REG_STAT = 5'h0c;
  localparam int CTRL_START = 31;
  localparam int CTRL_DUMMY = 11;
  localparam int CTRL_HASADDR = 10;

  function automatic logic [2:0] lane_w(input logic [1:0] m);
    case (m)
      LANE_2: lane_w = 3'h2;
      LANE_4: lane_w = 3'h4;
      default: lane_w = 3'h1;
    endcase
  endfunction : lane_w

  // single lane: host talks on io0, device answers on io1
  function automatic logic [3:0] lane_out(input logic [3:0] top, input logic [1:0] m,
                                          input logic dev);
    case (m)
      LANE_2: lane_out = {2'b00, top[3:2]};
      LANE_4: lane_out = top;
      default: lane_out = dev ? {2'b00, top[3], 1'b0} : {3'b000, top[3]};
    endcase
  endfunction : lane_out

  function automatic logic [3:0] lane_oe(input logic [1:0] m, input logic dev);
    case (m)
      LANE_2: lane_oe = 4'b0011;
      LANE_4: lane_oe = 4'b1111;
      default: lane_oe = dev ? 4'b0010 : 4'b0001;
    endcase
  endfunction : lane_oe

  function automatic logic [31:0] shin(input logic [31:0] x, input logic [3:0] io,
                                       input logic [1:0] m, input logic dev);
    case (m)
      LANE_2: shin = {x[29:0], io[1:0]};
      LANE_4: shin = {x[27:0], io};
      default: shin = {x[30:0], dev ? io[0] : io[1]};
    endcase
  endfunction : shin
endpackage : fptpo_pkg

// *** fptpo_rom.sv ***
// Purpose: parameter table contents, one byte per address
// Assumes: address already the full 24-bit byte address
// Notes: no write path exists
`timescale 1ns/1ns
module fptpo_rom (
  input wire logic [23:0] addr,
  output logic [7:0] data
);
  import fptpo_pkg::*;
  logic [23:0] off;
  assign off = addr - PT_BASE;
  always_comb begin
    case (off)
      24'h00_0000: data = PT_VMAX[7:0]; // R03
      24'h00_0001: data = PT_VMAX[15:8]; // R03
      24'h00_0002: data = PT_VMIN[7:0]; // R04
      24'h00_0003: data = PT_VMIN[15:8]; // R04
      24'h00_0004: data = PT_FEAT[7:0]; // R05
      24'h00_0005: data = PT_FEAT[15:8]; // R05
      24'h00_0008: data = PT_LOCK[7:0]; // R08
      24'h00_0009: data = PT_LOCK[15:8]; // R08
      default: data = BLANK; // R07 R09 R12
    endcase
  end
endmodule : fptpo_rom
